// [hw/ads_pkg.sv]
// ads_pkg: shared constants and types for the converter sequencer timing engine.
// Assumes one ref_clk cycle equals one modulator clock cycle.
package ads_pkg;

  // widths
  localparam int CNT_W    = 24;
  localparam int RATE_W   = 11;
  localparam int SETTLE_W = 3;
  localparam int MODE_W   = 4;
  localparam int PP_W     = 7;

  // front-end settling: base count for code 0, doubled per code step
  localparam logic [CNT_W-1:0]    SETTLE_BASE    = 24'h000020;
  localparam logic [SETTLE_W-1:0] SETTLE_DEFAULT = 3'h0;

  // conversion period multipliers and fixed post-filter periods
  localparam logic [CNT_W-1:0] SINC_MULT      = 24'h000020;
  localparam logic [CNT_W-1:0] SINC4_AVG_MULT = 24'h000160;
  localparam logic [CNT_W-1:0] SINC3_AVG_MULT = 24'h000140;
  localparam logic [CNT_W-1:0] POST1_PERIOD   = 24'h000B80;
  localparam logic [CNT_W-1:0] POST2_PERIOD   = 24'h000C80;
  localparam logic [CNT_W-1:0] POST3_PERIOD   = 24'h000F80;
  localparam logic [CNT_W-1:0] POST4_PERIOD   = 24'h001280;

  // postprocessing delays
  localparam logic [PP_W-1:0]   PP_SHORT       = 7'h1C;
  localparam logic [PP_W-1:0]   PP_LONG        = 7'h3E;
  localparam logic [PP_W-1:0]   PP_POST        = 7'h45;
  localparam logic [RATE_W-1:0] RATE_SHORT_MAX = 11'h001;

  // filter modes
  typedef enum logic [MODE_W-1:0] {
    MODE_SINC4       = 4'h0,
    MODE_SINC4_AVG   = 4'h1,
    MODE_SINC3       = 4'h2,
    MODE_SINC3_NOTCH = 4'h3,
    MODE_SINC3_AVG   = 4'h4,
    MODE_POST1       = 4'h5,
    MODE_POST2       = 4'h6,
    MODE_POST3       = 4'h7,
    MODE_POST4       = 4'h8
  } ads_mode_e;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_FIRST  = 4'b0100,
    ST_REPEAT = 4'b1000
  } ads_state_e;

endpackage

// [hw/ads_timing_calc.sv]
// ads_timing_calc: per-setup interval calculator (period, ideal first conversion,
// postprocessing delay). Purely combinational; caller registers what it needs.
`timescale 1ns/1ps
`default_nettype none
module ads_timing_calc
  import ads_pkg::*;
(
  // setup of the channel being timed
  input  wire logic [MODE_W-1:0] filterMode,
  input  wire logic [RATE_W-1:0] rateWord,
  // derived intervals in modulator cycles
  output logic      [CNT_W-1:0]  periodCycles,
  output logic      [CNT_W-1:0]  idealCycles,
  output logic      [PP_W-1:0]   postprocessDelay
);

  // rate 0 is timed as rate 1 so a period is never zero
  wire logic [CNT_W-1:0] rateValue = (rateWord == '0) ? CNT_W'(1) : CNT_W'(rateWord);
  wire logic isSinc4   = (filterMode == MODE_SINC4);
  wire logic isSinc3   = (filterMode == MODE_SINC3) || (filterMode == MODE_SINC3_NOTCH);
  wire logic isAvg4    = (filterMode == MODE_SINC4_AVG);
  wire logic isAvg3    = (filterMode == MODE_SINC3_AVG);
  wire logic isPost    = (filterMode >= MODE_POST1) && (filterMode <= MODE_POST4);
  wire logic shortRate = (rateWord <= RATE_SHORT_MAX);
  wire logic [CNT_W-1:0] sincPeriod = CNT_W'(rateValue * SINC_MULT);
  wire logic [CNT_W-1:0] postPeriod =
    (filterMode == MODE_POST1) ? POST1_PERIOD :
    (filterMode == MODE_POST2) ? POST2_PERIOD :
    (filterMode == MODE_POST3) ? POST3_PERIOD : POST4_PERIOD;

  // settled period per filter family
  assign periodCycles =
    isAvg4 ? CNT_W'(rateValue * SINC4_AVG_MULT) :
    isAvg3 ? CNT_W'(rateValue * SINC3_AVG_MULT) :
    isPost ? postPeriod :
             sincPeriod;

  // standalone sinc needs several periods to fill; averaging and post need one
  assign idealCycles =
    isSinc4 ? CNT_W'({sincPeriod, 2'b00}) :
    isSinc3 ? CNT_W'(sincPeriod + {sincPeriod, 1'b0}) :
              periodCycles;

  // postprocessing delay
  assign postprocessDelay =
    isPost                         ? PP_POST :
    ((isSinc4 || isSinc3) && shortRate) ? PP_SHORT : PP_LONG;

endmodule
`default_nettype wire

// [hw/ads_sequencer.sv]
// ads_sequencer: channel sequencer timing engine. Places settling, first and
// repeat conversions and the postprocessing delay for each enabled channel.
// Assumes ref_clk is the modulator clock and all config inputs are synchronous.
//
// Notes on behaviour
// - first result on a new channel comes after settle, ideal interval and postprocess delay
// - settle code selects 32 cycles doubled per step, 4096 at code seven
// - standalone sinc period is 32 times rate; first takes four or three periods
// - averaging period is 352 or 320 times rate; first equals one period
// - post filters use fixed periods 2944, 3200, 3968, 4736; first is one period
// - postprocess delay 28 for sinc at rate 0 or 1, else 62; post 69
// - rate word is the unsigned value of an eleven-bit field
// - switch channel at raw conversion end; data-ready falls after postprocess delay
// - new settle overlaps old postprocess; spacing is first time minus old delay
// - shared setup without repeats gives fixed period of settle plus ideal interval
// - per-channel rate is shared period times number of sharing channels
// - filter timing depends only on mode and rate, not on sequence rate
// - later conversions on one channel follow one period apart
// - sequencer cycles all enabled channels, repeating per channel setting
`timescale 1ns/1ps
`default_nettype none
module ads_sequencer
  import ads_pkg::*;
#(
  parameter int NCH   = 8,
  parameter int REP_W = 8
) (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  // control
  input  wire logic                    convEnable,
  input  wire logic [NCH-1:0]          chEnable,
  // per-channel setup, channel k in slice k
  input  wire logic [NCH*SETTLE_W-1:0] chSettle,
  input  wire logic [NCH*MODE_W-1:0]   chMode,
  input  wire logic [NCH*RATE_W-1:0]   chRate,
  input  wire logic [NCH*REP_W-1:0]    chRepeat,
  // status
  output logic [$clog2(NCH)-1:0]       activeChannel,
  output logic                         rawDone,
  output logic                         dataReadyN,
  output logic                         resultStrobe,
  output logic [$clog2(NCH)-1:0]       resultChannel,
  output logic                         sharedSetup,
  output logic [CNT_W-1:0]             sharedSetupOutputRate,
  output logic [$clog2(NCH+1)-1:0]     sharedChannels
);

  localparam int CHW = $clog2(NCH);

  ads_state_e            state_r, state_nxt;
  logic [CNT_W-1:0]      cnt_r, cnt_nxt;
  logic [CHW-1:0]        ch_r, ch_nxt, nextCh;
  logic [REP_W-1:0]      repLeft_r, repLeft_nxt;
  logic [PP_W-1:0]       ppCnt_r;
  logic [CHW-1:0]        ppCh_r;
  logic                  rawDone_r, dataReadyN_r, resultStrobe_r;
  logic [CHW-1:0]        resultCh_r;
  logic [CNT_W-1:0]      sharedRate_r;
  logic [SETTLE_W-1:0]   settleA [NCH];
  logic [MODE_W-1:0]     modeA   [NCH];
  logic [RATE_W-1:0]     rateA   [NCH];
  logic [REP_W-1:0]      repA    [NCH];
  logic [NCH-1:0]        sameSetup;
  logic [CNT_W-1:0]      periodCycles, idealCycles;
  logic [PP_W-1:0]       ppDelay;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel unpacking and shared-setup detection
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    assign settleA[k]   = chSettle[k*SETTLE_W +: SETTLE_W];
    assign modeA[k]     = chMode[k*MODE_W +: MODE_W];
    assign rateA[k]     = chRate[k*RATE_W +: RATE_W];
    assign repA[k]      = chRepeat[k*REP_W +: REP_W];
    // disabled channels never break sharing
    assign sameSetup[k] = !chEnable[k] || ((settleA[k] == settleA[ch_r])
                          && (modeA[k] == modeA[ch_r]) && (rateA[k] == rateA[ch_r])
                          && (repA[k] == '0));
  end

  // round-robin search for the next enabled channel after the active one
  always_comb begin
    nextCh = ch_r;
    for (int k = NCH; k >= 1; k--) begin
      if (chEnable[CHW'((int'(ch_r) + k) % NCH)]) begin
        nextCh = CHW'((int'(ch_r) + k) % NCH);
      end
    end
  end

  // interval calculator for the active channel's setup
  ads_timing_calc u_calc (
    .filterMode       (modeA[ch_r]),
    .rateWord         (rateA[ch_r]),
    .periodCycles     (periodCycles),
    .idealCycles      (idealCycles),
    .postprocessDelay (ppDelay)
  );

  // settle count of a channel: base shifted by its code
  wire logic [CNT_W-1:0] settleCur  = SETTLE_BASE << settleA[ch_r];
  wire logic [CNT_W-1:0] settleNext = SETTLE_BASE << settleA[nextCh];
  wire logic             anyEnabled = |chEnable;
  wire logic             segEnd     = (cnt_r == CNT_W'(1));
  wire logic             convEnd    = segEnd && (state_r == ST_FIRST || state_r == ST_REPEAT);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state machine; a single down-counter times every segment
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = (cnt_r > CNT_W'(1)) ? cnt_r - CNT_W'(1) : cnt_r;
    ch_nxt      = ch_r;
    repLeft_nxt = repLeft_r;
    case (state_r)
      ST_IDLE: begin
        if (convEnable && anyEnabled) begin
          ch_nxt    = nextCh;
          cnt_nxt   = settleNext;
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (segEnd) begin
          cnt_nxt     = idealCycles;
          repLeft_nxt = repA[ch_r];
          state_nxt   = ST_FIRST;
        end
      end
      default: begin
        // raw conversion over: switch at once, postprocessing runs behind it
        if (convEnd) begin
          if (repLeft_r != '0) begin
            repLeft_nxt = repLeft_r - REP_W'(1);
            cnt_nxt     = periodCycles;
            state_nxt   = ST_REPEAT;
          end else begin
            ch_nxt    = nextCh;
            cnt_nxt   = settleNext;
            state_nxt = ST_SETTLE;
          end
        end
      end
    endcase
    // dropping the enable aborts the sequence cleanly
    if (!convEnable || !anyEnabled) begin
      state_nxt = ST_IDLE;
      cnt_nxt   = '0;
    end
  end

  // state registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= ST_IDLE;
      cnt_r     <= '0;
      ch_r      <= CHW'(NCH - 1);
      repLeft_r <= '0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      ch_r      <= ch_nxt;
      repLeft_r <= repLeft_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // postprocessing tail: overlaps the next channel's settle; data-ready falls
  // only when it expires. the shortest period always exceeds the delay.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ppCnt_r        <= '0;
      ppCh_r         <= '0;
      rawDone_r      <= 1'b0;
      dataReadyN_r   <= 1'b1;
      resultStrobe_r <= 1'b0;
      resultCh_r     <= '0;
    end else begin
      rawDone_r      <= convEnd;
      resultStrobe_r <= (ppCnt_r == PP_W'(1));
      if (convEnd) begin
        ppCnt_r      <= ppDelay;
        ppCh_r       <= ch_r;
        dataReadyN_r <= 1'b1;
      end else if (ppCnt_r == PP_W'(1)) begin
        ppCnt_r      <= '0;
        dataReadyN_r <= 1'b0;
        resultCh_r   <= ppCh_r;
      end else if (ppCnt_r != '0) begin
        ppCnt_r <= ppCnt_r - PP_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared-setup report: fixed result period and enabled channel count.
  // filter timing above never looks at these, so the response is unchanged.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sharedRate_r <= '0;
    end else begin
      sharedRate_r <= settleCur + idealCycles;
    end
  end

  always_comb begin
    sharedChannels = '0;
    for (int k = 0; k < NCH; k++) begin
      sharedChannels = sharedChannels + ($clog2(NCH+1))'(chEnable[k]);
    end
  end

  assign sharedSetup           = anyEnabled && (&sameSetup);
  assign sharedSetupOutputRate = sharedRate_r;
  assign activeChannel         = ch_r;
  assign rawDone               = rawDone_r;
  assign dataReadyN            = dataReadyN_r;
  assign resultStrobe          = resultStrobe_r;
  assign resultChannel         = resultCh_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks: segment lengths measured independently of the down-counter
  logic [CNT_W-1:0] segLen_r;
  logic [PP_W-1:0]  ppLen_r;
  logic [PP_W-1:0]  ppExp_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      segLen_r <= '0;
      ppLen_r  <= '0;
      ppExp_r  <= '0;
    end else begin
      segLen_r <= (state_nxt != state_r || convEnd) ? '0 : segLen_r + CNT_W'(1);
      ppLen_r  <= convEnd ? '0 : ppLen_r + PP_W'(1);
      if (convEnd) ppExp_r <= ppDelay;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_settle_len: assert property (state_r == ST_SETTLE && segEnd && convEnable && anyEnabled
    |-> segLen_r + CNT_W'(1) == (SETTLE_BASE << settleA[ch_r]))
    else $error("settle segment length wrong");
  a_first_len: assert property (state_r == ST_FIRST && segEnd && convEnable && anyEnabled
    |-> segLen_r + CNT_W'(1) == idealCycles)
    else $error("first conversion length wrong");
  a_repeat_len: assert property (state_r == ST_REPEAT && segEnd && convEnable && anyEnabled
    |-> segLen_r + CNT_W'(1) == periodCycles)
    else $error("repeat conversion length wrong");
  a_result_after_pp: assert property ($rose(resultStrobe_r)
    |-> ppLen_r == ppExp_r && !dataReadyN_r)
    else $error("data ready not after postprocess delay");
  a_switch_on_done: assert property (convEnd && repLeft_r == '0 && convEnable && anyEnabled
    |=> state_r == ST_SETTLE && ch_r == $past(nextCh))
    else $error("channel switch not at raw conversion end");
  a_pp_post: assert property (modeA[ch_r] >= MODE_POST1 && modeA[ch_r] <= MODE_POST4
    |-> ppDelay == PP_POST)
    else $error("post filter delay wrong");
  a_pp_sinc_short: assert property ((modeA[ch_r] == MODE_SINC3 || modeA[ch_r] == MODE_SINC4)
    && rateA[ch_r] <= RATE_SHORT_MAX |-> ppDelay == PP_SHORT)
    else $error("short sinc delay wrong");
  a_sinc3_period: assert property (modeA[ch_r] == MODE_SINC3_NOTCH && rateA[ch_r] != '0
    |-> periodCycles == CNT_W'(rateA[ch_r]) * SINC_MULT
        && idealCycles == periodCycles * CNT_W'(3))
    else $error("sinc3 period or first interval wrong");
  a_avg_period: assert property (modeA[ch_r] == MODE_SINC3_AVG && rateA[ch_r] != '0
    |-> periodCycles == CNT_W'(rateA[ch_r]) * SINC3_AVG_MULT
        && idealCycles == periodCycles)
    else $error("averaging period wrong");
  a_post3_period: assert property (modeA[ch_r] == MODE_POST3
    |-> periodCycles == POST3_PERIOD && idealCycles == POST3_PERIOD)
    else $error("post filter period wrong");

endmodule
`default_nettype wire

// [sim/ads_host_model.sv]
// ads_host_model: host-side collector that timestamps raw conversion ends and
// data-ready falls, with the channel of each result.
// Assumes the bench holds every channel setup stable while conversions run.
`timescale 1ns/1ps
`default_nettype none
module ads_host_model
#(
  parameter int CHW = 2
) (
  // clock and reset
  input wire logic           ref_clk,
  input wire logic           rstn,
  // result status from the sequencer
  input wire logic           rawDone,
  input wire logic           dataReadyN,
  input wire logic           resultStrobe,
  input wire logic [CHW-1:0] resultChannel
);
  //////////////////////////////////////////////////////////////////////////////
  int             cyc = 0; // free-running edge index, read by the bench
  int             rawQ[$];
  int             fallQ[$];
  logic [CHW-1:0] chQ[$];
  logic           drnQ[$]; // data-ready level seen with each raw end

  // log events; a strobe without data-ready low is not counted as a result
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (!rstn) begin
      rawQ.delete();
      fallQ.delete();
      chQ.delete();
      drnQ.delete();
    end else begin
      if (rawDone) begin
        rawQ.push_back(cyc);
        drnQ.push_back(dataReadyN);
      end
      if (resultStrobe && !dataReadyN) begin
        fallQ.push_back(cyc);
        chQ.push_back(resultChannel);
      end
    end
  end
endmodule
`default_nettype wire

// [sim/tb_adc_sequencer_conversion_timing.sv]
// tb_adc_sequencer_conversion_timing: scenario bench for the sequencer timing.
// Assumes ref_clk is the modulator clock; events are seen one edge after they rise.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sequencer_conversion_timing
  import ads_pkg::*;
;
  //////////////////////////////////////////////////////////////////////////////
  localparam int NCH = 4;
  localparam int CHW = 2;
  logic                    ref_clk    = 1'b0;
  logic                    rstn       = 1'b0;
  logic                    convEnable = 1'b0;
  logic [NCH-1:0]          chEnable   = '0;
  logic [NCH*SETTLE_W-1:0] chSettle   = '0;
  logic [NCH*MODE_W-1:0]   chMode     = '0;
  logic [NCH*RATE_W-1:0]   chRate     = '0;
  logic [NCH*8-1:0]        chRepeat   = '0;
  logic [CHW-1:0]          activeChannel;
  logic                    rawDone;
  logic                    dataReadyN;
  logic                    resultStrobe;
  logic [CHW-1:0]          resultChannel;
  logic                    sharedSetup;
  logic [CNT_W-1:0]        sharedSetupOutputRate;
  logic [2:0]              sharedChannels;
  int                      bad_count = 0;
  int                      checks    = 0;
  int                      startCyc  = 0;

  // 200 MHz modulator clock
  always #2.5 ref_clk = ~ref_clk;

  ads_sequencer #(.NCH(NCH), .REP_W(8)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .convEnable(convEnable), .chEnable(chEnable),
    .chSettle(chSettle), .chMode(chMode), .chRate(chRate), .chRepeat(chRepeat),
    .activeChannel(activeChannel), .rawDone(rawDone), .dataReadyN(dataReadyN),
    .resultStrobe(resultStrobe), .resultChannel(resultChannel),
    .sharedSetup(sharedSetup), .sharedSetupOutputRate(sharedSetupOutputRate),
    .sharedChannels(sharedChannels));

  ads_host_model #(.CHW(CHW)) host (
    .ref_clk(ref_clk), .rstn(rstn), .rawDone(rawDone), .dataReadyN(dataReadyN),
    .resultStrobe(resultStrobe), .resultChannel(resultChannel));

  //////////////////////////////////////////////////////////////////////////////
  // expected intervals; rate 0 is timed as rate 1 for the period
  function automatic int e_period(input int md, input int rt);
    int r;
    r = (rt == 0) ? 1 : rt;
    case (md)
      1: return 352 * r;
      4: return 320 * r;
      5: return 2944;
      6: return 3200;
      7: return 3968;
      8: return 4736;
      default: return 32 * r;
    endcase
  endfunction

  function automatic int e_ideal(input int md, input int rt);
    if (md == 0) return 4 * e_period(md, rt);
    if (md == 2 || md == 3) return 3 * e_period(md, rt);
    return e_period(md, rt);
  endfunction

  function automatic int e_pp(input int md, input int rt);
    if (md >= 5) return 69;
    if (md == 1 || md == 4 || rt > 1) return 62;
    return 28;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic set_ch(input int ch, input int st, input int md, input int rt, input int rp);
    chSettle[ch*SETTLE_W +: SETTLE_W] = SETTLE_W'(st);
    chMode[ch*MODE_W +: MODE_W]       = MODE_W'(md);
    chRate[ch*RATE_W +: RATE_W]       = RATE_W'(rt);
    chRepeat[ch*8 +: 8]               = 8'(rp);
  endtask

  // reset held for two edges, idle outputs checked while held
  task automatic reset_dut();
    @(posedge ref_clk);
    #1;
    rstn = 1'b0;
    convEnable = 1'b0;
    chEnable = '0;
    chSettle = '0;
    chMode = '0;
    chRate = '0;
    chRepeat = '0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("dataReadyN idle", dataReadyN, 1'b1);
    check("rawDone idle", rawDone, 1'b0);
    check("activeChannel idle", activeChannel, NCH - 1);
    rstn = 1'b1;
  endtask

  task automatic go(input int first);
    @(posedge ref_clk);
    #1;
    convEnable = 1'b1;
    startCyc = host.cyc;
    repeat (2) @(posedge ref_clk);
    #1 check("activeChannel first", activeChannel, first);
  endtask

  task automatic wait_falls(input int n);
    int k;
    k = 0;
    while (host.fallQ.size() < n && k < 20000) begin
      @(posedge ref_clk);
      k++;
    end
    #1 check("result count", host.fallQ.size(), n);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // one channel alone: first result timing, then the shared fixed spacing
  task automatic run_single(input int ch, input int st, input int md, input int rt);
    int s;
    int i;
    int p;
    s = 32 << st;
    i = e_ideal(md, rt);
    p = e_pp(md, rt);
    reset_dut();
    set_ch(ch, st, md, rt, 0);
    chEnable = NCH'(1) << ch;
    go(ch);
    wait_falls(2);
    check("raw end", host.rawQ[0] - startCyc, s + i + 1);
    check("first result", host.fallQ[0] - startCyc, s + i + p + 1);
    check("result after raw", host.fallQ[0] - host.rawQ[0], p);
    check("data ready high at raw end", host.drnQ[0], 1'b1);
    check("data ready low after result", dataReadyN, 1'b0);
    check("result spacing", host.fallQ[1] - host.fallQ[0], s + i);
    check("shared rate", sharedSetupOutputRate, s + i);
    check("result channel", host.chQ[1], ch);
  endtask

  // repeat on channel 0, then switch to a channel with a longer delay
  task automatic run_repeat_switch();
    int k;
    reset_dut();
    set_ch(0, 0, 3, 1, 1);
    set_ch(1, 1, 2, 2, 0);
    chEnable = 4'b0011;
    go(0);
    check("mixed setup flag", sharedSetup, 1'b0);
    wait_falls(4);
    check("repeat spacing", host.fallQ[1] - host.fallQ[0], 32);
    check("switch spacing", host.fallQ[2] - host.fallQ[1], 64 + 192 + 62 - 28);
    check("switch at raw end", host.rawQ[2] - host.rawQ[1], 64 + 192);
    check("return spacing", host.fallQ[3] - host.fallQ[2], 32 + 96 + 28 - 62);
    for (k = 0; k < 4; k++) begin
      check("sequence channel", host.chQ[k], (k == 2));
    end
  endtask

  // two enabled channels share one setup; disabled channel 0 differs
  task automatic run_shared();
    int k;
    reset_dut();
    set_ch(0, 5, 8, 1, 0);
    set_ch(1, 1, 3, 2, 0);
    set_ch(3, 1, 3, 2, 0);
    chEnable = 4'b1010;
    go(1);
    check("shared flag", sharedSetup, 1'b1);
    check("shared count", sharedChannels, 2);
    wait_falls(4);
    check("shared rate", sharedSetupOutputRate, 64 + 192);
    for (k = 1; k < 4; k++) begin
      check("shared spacing", host.fallQ[k] - host.fallQ[k-1], 256);
      check("shared channel", host.chQ[k], (k % 2 == 0) ? 1 : 3);
    end
    check("per channel spacing", host.fallQ[2] - host.fallQ[0], 2 * 256);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence: every mode and settle code, then sequencing cases
  initial begin
    run_single(0, 0, 3, 1);
    run_single(1, 7, 0, 1);
    run_single(2, 1, 2, 0);
    run_single(3, 2, 3, 2);
    run_single(0, 3, 1, 3);
    run_single(1, 0, 4, 2);
    run_single(2, 4, 5, 2047);
    run_single(3, 5, 6, 2047);
    run_single(0, 6, 7, 2047);
    run_single(1, 0, 8, 2047);
    run_repeat_switch();
    run_shared();
    complete_run();
  end

  // watchdog at 80k cycles, past the roughly 53k cycles the scenarios need
  initial begin
    #400000;
    bad_count++;
    $display("watchdog expired");
    complete_run();
  end
endmodule
`default_nettype wire
